// *** src/spi_link_if.sv ***
/*
 Serial link between controller and flash end.
 Assumes a pull-up on every data line when nobody drives it.
*/
`timescale 1ns/10ps
`default_nettype none
interface spi_link_if;
    logic sck;
    logic csN;
    logic [3:0] hostIoOut;
    logic [3:0] hostIoOe_n;
    logic devSoOut;
    logic devSoOe_n;
    wire [3:0] io;
    // Resolved line levels
    assign io[0] = !hostIoOe_n[0] ? hostIoOut[0] : 1'b1;
    assign io[1] = !hostIoOe_n[1] ? hostIoOut[1] :
                   (!devSoOe_n ? devSoOut : 1'b1);
    assign io[2] = !hostIoOe_n[2] ? hostIoOut[2] : 1'b1;
    assign io[3] = !hostIoOe_n[3] ? hostIoOut[3] : 1'b1;
    modport flash (input sck, csN, io, output devSoOut, devSoOe_n);
    modport ctrl (output sck, csN, hostIoOut, hostIoOe_n, input io);
endinterface
`default_nettype wire

// *** src/xip_erase_flash.sv ***
/*
 Flash end: command decode, quad read dummy setup, page erase.
 Assumes the link pins are asynchronous to clk and slow enough
 for edge detection by sampling.
*/
`include "xip_erase_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module xip_erase_flash #(
    parameter int ERASE_CYCLES = `PE_TIME_US * 1000 / `CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link
    spi_link_if.flash link,
    // Core side
    input wire logic [7:0] statusFive,
    input wire logic protect,
    input wire logic eraseFail,
    output logic [7:0] statusOne,
    output logic [7:0] statusFour,
    output logic [3:0] dummyClocks,
    output logic eraseStart,
    output logic [12:0] erasePage,
    output logic readStart,
    output logic [23:0] readAddr,
    output logic contRead
);
    //--------------------------------------------------------
    // Pin synchronisers
    //--------------------------------------------------------
    logic [2:0] sckS;
    logic [2:0] csS;
    logic [3:0] ioS1;
    logic [3:0] ioS2;
    always_ff @(posedge clk)
    begin
        sckS <= {sckS[1:0], link.sck};
        csS <= {csS[1:0], link.csN};
        ioS1 <= link.io;
        ioS2 <= ioS1;
    end
    wire sckRise = sckS[1] & ~sckS[2];
    wire sckFall = ~sckS[1] & sckS[2];
    wire csLow = ~csS[1];
    wire csFall = ~csS[1] & csS[2];
    wire csRise = csS[1] & ~csS[2];
    //--------------------------------------------------------
    // Decode
    //--------------------------------------------------------
    xip_erase_pkg::dev_state_t state;
    logic [5:0] frameBits;
    logic [3:0] phase;
    logic [7:0] shreg;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [7:0] modeByte;
    logic [7:0] statSh;
    logic alignQ;
    logic write_latch_flag;
    logic busy;
    logic [31:0] eraseCnt;
    logic soOut;
    logic soOe_n;
    wire [2:0] dcSel = statusFive[`SR5_DC_MSB:`SR5_DC_LSB];
    wire word_align_mode = statusFive[`SR5_DWA_BIT];
    wire [3:0] selDummy = (dcSel > `DC_MAX_SEL) ? `DUMMY_MAX :
                          4'({dcSel, 1'b0}) + `DUMMY_MODE;
    wire [7:0] opcNext = {shreg[6:0], ioS2[0]};
    wire [7:0] modeNext = {modeByte[3:0], ioS2};
    wire isErase = (opcode == `OPC_PE_A) || (opcode == `OPC_PE_B);
    wire opcDone = (state == xip_erase_pkg::ST_OPC) && phase == 4'h7;
    wire bitStep = csLow && sckRise;
    wire [5:0] nextBits = (frameBits == 6'h3F) ? frameBits :
                          frameBits + 6'h01;
    wire isQuad = (opcNext == `OPC_QRD) || (opcNext == `OPC_QRD_AL);
    wire nextAlign = (opcNext == `OPC_QRD_AL) || word_align_mode;
    wire dummyEnd = phase == dummyClocks - 4'h3;
    xip_erase_pkg::dev_state_t decoded;
    assign decoded = isQuad ? xip_erase_pkg::ST_QADDR :
        ((opcNext == `OPC_PE_A) || (opcNext == `OPC_PE_B)) ?
            xip_erase_pkg::ST_ADDR :
        (opcNext == `OPC_RDSR1) ? xip_erase_pkg::ST_STAT :
        (opcNext == `OPC_ASI) ? xip_erase_pkg::ST_ASI :
            xip_erase_pkg::ST_IGNORE;
    wire eraseOk = csRise && isErase
        && frameBits >= `ERASE_BITS
        && frameBits[2:0] == 3'h0
        && write_latch_flag
        && !busy
        && !protect;
    wire wrenOk = csRise && opcode == `OPC_WREN
        && frameBits == `OPC_BITS;
    wire loadStat = bitStep && opcDone && opcNext == `OPC_RDSR1;
    wire eraseEnd = busy && eraseCnt == 32'(ERASE_CYCLES - 1);
    //--------------------------------------------------------
    // Frame state machine
    //--------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state <= xip_erase_pkg::ST_IGNORE;
            frameBits <= 6'h00;
            phase <= 4'h0;
            shreg <= 8'h00;
            opcode <= 8'h00;
            addr <= 24'h000000;
            modeByte <= 8'h00;
            alignQ <= 1'b0;
            contRead <= 1'b0;
            readStart <= 1'b0;
            readAddr <= 24'h000000;
        end
        else
        begin
            readStart <= 1'b0;
            if (csFall)
            begin
                state <= contRead ? xip_erase_pkg::ST_QADDR :
                         xip_erase_pkg::ST_OPC;
                frameBits <= 6'h00;
                phase <= 4'h0;
            end
            else if (csRise)
                state <= xip_erase_pkg::ST_IGNORE;
            else if (bitStep)
            begin
                frameBits <= nextBits;
                phase <= phase + 4'h1;
                case (state)
                    xip_erase_pkg::ST_OPC:
                    begin
                        shreg <= opcNext;
                        if (phase == 4'h7)
                        begin
                            opcode <= opcNext;
                            phase <= 4'h0;
                            state <= decoded;
                            if (isQuad)
                                alignQ <= nextAlign;
                        end
                    end
                    xip_erase_pkg::ST_ADDR:
                    begin
                        addr <= {addr[22:0], ioS2[0]};
                        if (nextBits == `ERASE_BITS)
                            state <= xip_erase_pkg::ST_IGNORE;
                    end
                    xip_erase_pkg::ST_QADDR:
                    begin
                        addr <= {addr[19:0], ioS2};
                        if (phase == `QADDR_LAST)
                        begin
                            phase <= 4'h0;
                            state <= xip_erase_pkg::ST_QMODE;
                        end
                    end
                    xip_erase_pkg::ST_QMODE:
                    begin
                        modeByte <= modeNext;
                        if (phase == `MODE_LAST)
                        begin
                            contRead <= modeNext[5:4] == `MODE_CONT;
                            phase <= 4'h0;
                            if (dummyClocks == `DUMMY_MODE)
                            begin
                                state <= xip_erase_pkg::ST_QDATA;
                                readStart <= 1'b1;
                                readAddr <= alignQ ?
                                    {addr[23:2], 2'b00} : addr;
                            end
                            else
                                state <= xip_erase_pkg::ST_QDUMMY;
                        end
                    end
                    xip_erase_pkg::ST_QDUMMY:
                    begin
                        if (dummyEnd)
                        begin
                            state <= xip_erase_pkg::ST_QDATA;
                            readStart <= 1'b1;
                            readAddr <= alignQ ?
                                {addr[23:2], 2'b00} : addr;
                        end
                    end
                    default:
                    begin
                    end
                endcase
            end
        end
    end
    //--------------------------------------------------------
    // Erase timer and flags
    //--------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            write_latch_flag <= 1'b0;
            busy <= 1'b0;
            eraseCnt <= 32'h00000000;
            eraseStart <= 1'b0;
            erasePage <= 13'h0000;
            statusFour <= 8'h00;
            dummyClocks <= `DUMMY_MODE;
        end
        else
        begin
            dummyClocks <= selDummy;
            eraseStart <= 1'b0;
            if (eraseOk)
            begin
                busy <= 1'b1;
                eraseCnt <= 32'h00000000;
                eraseStart <= 1'b1;
                erasePage <= addr[`PAGE_MSB:`PAGE_LSB];
                write_latch_flag <= 1'b0;
                statusFour[`SR4_EE_BIT] <= 1'b0;
                statusFour[`SR4_PE_BIT] <= 1'b0;
            end
            else if (eraseEnd)
            begin
                busy <= 1'b0;
                statusFour[`SR4_EE_BIT] <= eraseFail;
                statusFour[`SR4_PE_BIT] <= eraseFail;
            end
            else if (busy)
                eraseCnt <= eraseCnt + 32'h00000001;
            if (wrenOk)
                write_latch_flag <= 1'b1;
        end
    end
    assign statusOne = {6'h00, write_latch_flag, busy};
    //--------------------------------------------------------
    // Serial output
    //--------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            soOut <= 1'b1;
            soOe_n <= 1'b1;
            statSh <= 8'h00;
        end
        else
        begin
            soOe_n <= !(csLow && !csFall &&
                (state == xip_erase_pkg::ST_STAT ||
                 state == xip_erase_pkg::ST_ASI));
            if (loadStat)
                statSh <= statusOne;
            else if (state == xip_erase_pkg::ST_STAT && sckFall)
            begin
                soOut <= statSh[7];
                statSh <= {statSh[6:0], statSh[7]};
            end
            else if (state == xip_erase_pkg::ST_ASI)
                soOut <= busy;
        end
    end
    assign link.devSoOut = soOut;
    assign link.devSoOe_n = soOe_n;
endmodule
`default_nettype wire

// *** src/xip_erase_host.sv ***
/*
 Controller end: AHB-Lite register slave and serial engine.
 Assumes a single-master AHB-Lite bus on clk.
*/
`include "xip_erase_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module xip_erase_host #(
    parameter int SCK_HALF = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Link
    spi_link_if.ctrl link
);
    //--------------------------------------------------------
    // Registers
    //--------------------------------------------------------
    xip_erase_pkg::host_state_t hState;
    logic [7:0] wrAddr;
    logic wrPend;
    logic [23:0] addrReg;
    logic [3:0] dummyReg;
    logic [1:0] kind;
    logic quad;
    logic [39:0] txSh;
    logic [7:0] rxByte;
    logic [7:0] clkIdx;
    logic [7:0] divCnt;
    logic [1:0] soS;
    logic sawOne;
    logic doneSeen;
    logic sck;
    logic csN;
    logic [3:0] ioOut;
    logic [3:0] ioOe_n;
    wire active = hState != xip_erase_pkg::H_IDLE;
    wire addrPhase = hsel && htrans[1] && hready;
    wire startReq = wrPend && wrAddr == `HOST_CMD_OFS && !active;
    wire tick = divCnt == 8'(SCK_HALF - 1);
    wire [7:0] rdA = haddr[7:0];
    wire [31:0] rdMux =
        (rdA == `HOST_ADDR_OFS) ? {8'h00, addrReg} :
        (rdA == `HOST_STAT_OFS) ? {16'h0000, rxByte, 7'h00, active} :
        (rdA == `HOST_DUMMY_OFS) ? {28'h0000000, dummyReg} :
        32'h00000000;
    wire [7:0] total = quad ? `TOT_QBASE + {4'h0, dummyReg} :
        (kind == `KIND_ADDR) ? `TOT_ADDR :
        (kind == `KIND_READ) ? `TOT_READ : `TOT_OPC;
    wire lastClk = (kind == `KIND_ASI && !quad) ?
        (doneSeen && clkIdx[2:0] == 3'h0) :
        clkIdx == total;
    wire quadFirst = quad && clkIdx == 8'h08;
    wire quadMore = quad && clkIdx > 8'h08 && clkIdx < 8'h10;
    wire released = quad && clkIdx >= 8'h10;
    wire [39:0] txS1 = {txSh[38:0], 1'b0};
    wire [39:0] txS4 = {txSh[35:0], 4'h0};
    //--------------------------------------------------------
    // Bus slave
    //--------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
            wrPend <= 1'b0;
            wrAddr <= 8'h00;
            addrReg <= 24'h000000;
            dummyReg <= `DUMMY_MODE;
        end
        else
        begin
            wrPend <= addrPhase && hwrite;
            if (addrPhase)
                wrAddr <= haddr[7:0];
            if (addrPhase && !hwrite)
                hrdata <= rdMux;
            if (wrPend && wrAddr == `HOST_ADDR_OFS)
                addrReg <= hwdata[23:0];
            if (wrPend && wrAddr == `HOST_DUMMY_OFS)
                dummyReg <= hwdata[3:0];
        end
    end
    //--------------------------------------------------------
    // Serial engine
    //--------------------------------------------------------
    always_ff @(posedge clk)
    begin
        soS <= {soS[0], link.io[1]};
    end
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            hState <= xip_erase_pkg::H_IDLE;
            sck <= 1'b0;
            csN <= 1'b1;
            ioOut <= 4'hF;
            ioOe_n <= 4'hF;
            divCnt <= 8'h00;
            clkIdx <= 8'h00;
            txSh <= 40'h0000000000;
            rxByte <= 8'h00;
            kind <= `KIND_OPC;
            quad <= 1'b0;
            sawOne <= 1'b0;
            doneSeen <= 1'b0;
        end
        else
        begin
            divCnt <= (tick || !active) ? 8'h00 : divCnt + 8'h01;
            case (hState)
                xip_erase_pkg::H_IDLE:
                    if (startReq)
                    begin
                        txSh <= {hwdata[7:0], addrReg, 8'h00};
                        kind <= hwdata[9:8];
                        quad <= hwdata[`CMD_QUAD_BIT];
                        csN <= 1'b0;
                        ioOut <= {3'h7, hwdata[7]};
                        ioOe_n <= 4'hE;
                        clkIdx <= 8'h00;
                        sawOne <= 1'b0;
                        doneSeen <= 1'b0;
                        hState <= xip_erase_pkg::H_SETUP;
                    end
                xip_erase_pkg::H_SETUP:
                    if (tick)
                        hState <= xip_erase_pkg::H_RUN;
                xip_erase_pkg::H_RUN:
                    if (tick && !sck)
                    begin
                        sck <= 1'b1;
                        clkIdx <= clkIdx + 8'h01;
                        rxByte <= {rxByte[6:0], soS[1]};
                        if (soS[1])
                            sawOne <= 1'b1;
                        if (sawOne && !soS[1])
                            doneSeen <= 1'b1;
                    end
                    else if (tick)
                    begin
                        sck <= 1'b0;
                        if (lastClk)
                        begin
                            ioOe_n <= 4'hF;
                            hState <= xip_erase_pkg::H_END;
                        end
                        else if (quadFirst || quadMore)
                        begin
                            txSh <= quadFirst ? txS1 : txS4;
                            ioOut <= quadFirst ? txS1[39:36] :
                                     txS4[39:36];
                            ioOe_n <= 4'h0;
                        end
                        else if (released)
                            ioOe_n <= 4'hF;
                        else
                        begin
                            txSh <= txS1;
                            ioOut <= {3'h7, txS1[39]};
                        end
                    end
                xip_erase_pkg::H_END:
                    if (tick)
                    begin
                        csN <= 1'b1;
                        hState <= xip_erase_pkg::H_GAP;
                    end
                default:
                    if (tick)
                        hState <= xip_erase_pkg::H_IDLE;
            endcase
        end
    end
    assign link.sck = sck;
    assign link.csN = csN;
    assign link.hostIoOut = ioOut;
    assign link.hostIoOe_n = ioOe_n;
endmodule
`default_nettype wire

// *** src/xip_erase_pkg.sv ***
/*
 Types shared by both ends of the serial flash link.
 Assumes nothing beyond the constants header.
*/
package xip_erase_pkg;
    typedef enum logic [3:0]
    {
        ST_OPC, ST_ADDR, ST_QADDR, ST_QMODE, ST_QDUMMY,
        ST_QDATA, ST_STAT, ST_ASI, ST_IGNORE
    } dev_state_t;
    typedef enum logic [2:0]
    {
        H_IDLE, H_SETUP, H_RUN, H_END, H_GAP
    } host_state_t;
endpackage

// *** src/xip_erase_regs.svh ***
/*
 Constants for the quad read dummy setup and page erase link.
 Assumes a 100 MHz system clock and a mode 0 serial link.
*/
//------------------------------------------------------------
//------------------------------------------------------------
`ifndef XIP_ERASE_REGS_SVH
`define XIP_ERASE_REGS_SVH
`define CLK_PERIOD_NS 10
`define PE_TIME_US 1000
`define OPC_WREN 8'h06
`define OPC_PE_A 8'h81
`define OPC_PE_B 8'hDB
`define OPC_QRD 8'hEB
`define OPC_QRD_AL 8'hE7
`define OPC_RDSR1 8'h05
`define OPC_ASI 8'h25
`define OPC_BITS 6'h08
`define ERASE_BITS 6'h20
`define QADDR_LAST 4'h5
`define MODE_LAST 4'h1
`define DUMMY_MODE 4'h2
`define DUMMY_MAX 4'hA
`define DC_MAX_SEL 3'h4
`define SR5_DC_MSB 6
`define SR5_DC_LSB 4
`define SR5_DWA_BIT 0
`define SR4_EE_BIT 5
`define SR4_PE_BIT 4
`define PAGE_MSB 20
`define PAGE_LSB 8
`define MODE_CONT 2'h2
`define HOST_CMD_OFS 8'h00
`define HOST_ADDR_OFS 8'h04
`define HOST_STAT_OFS 8'h08
`define HOST_DUMMY_OFS 8'h0C
`define KIND_OPC 2'h0
`define KIND_ADDR 2'h1
`define KIND_READ 2'h2
`define KIND_ASI 2'h3
`define CMD_QUAD_BIT 10
`define TOT_OPC 8'h08
`define TOT_ADDR 8'h20
`define TOT_READ 8'h10
`define TOT_QBASE 8'h0E
`endif

// *** tb/testbench.sv ***
/*
 Testbench: AHB-Lite controller driving the flash end.
 Assumes the two ends meet in spi_link_if.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
    //--------------------------------------------------------
    // Signals and ends
    //--------------------------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0] statusFive = 8'h00;
    logic protect = 1'b0;
    logic eraseFail = 1'b0;
    logic hreadyout, hresp, eraseStart, readStart, contRead;
    logic [31:0] hrdata, rd;
    logic [7:0] statusOne, statusFour;
    logic [3:0] dummyClocks;
    logic [12:0] erasePage;
    logic [23:0] readAddr;
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    int erases = 0;
    int reads = 0;
    spi_link_if link ();
    always #5 clk = ~clk;
    xip_erase_host xip_erase_host_i (.clk(clk), .rst_n(rst_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .link(link));
    xip_erase_flash #(.ERASE_CYCLES(2000)) xip_erase_flash_i (
        .clk(clk), .rst_n(rst_n), .link(link),
        .statusFive(statusFive), .protect(protect),
        .eraseFail(eraseFail), .statusOne(statusOne),
        .statusFour(statusFour), .dummyClocks(dummyClocks),
        .eraseStart(eraseStart), .erasePage(erasePage),
        .readStart(readStart), .readAddr(readAddr),
        .contRead(contRead));
    xip_erase_sva xip_erase_sva_i (.clk(clk), .rst_n(rst_n),
        .sck(link.sck), .csN(link.csN), .hostIoOut(link.hostIoOut),
        .hostIoOe_n(link.hostIoOe_n), .devSoOe_n(link.devSoOe_n));
    //--------------------------------------------------------
    // Tasks
    //--------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            failures++;
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic cmd(input logic [31:0] c);
        xfer(1'b1, 32'h0, c);
        xfer(1'b0, 32'h8, 32'h0);
        while (rd[0] === 1'b1)
            xfer(1'b0, 32'h8, 32'h0);
        repeat (8) @(posedge clk);
    endtask
    task automatic test_done();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (eraseStart === 1'b1)
            erases++;
        if (readStart === 1'b1)
            reads++;
        if (cycles == 40000)
        begin
            failures++;
            test_done();
        end
    end
    //--------------------------------------------------------
    // Sequence
    //--------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        xfer(1'b0, 32'hC, 32'h0);
        check(rd, 32'h2);
        check(32'(hresp), 32'h0);
        check(32'(dummyClocks), 32'h2);
        xfer(1'b0, 32'h10, 32'h0);
        check(rd, 32'h0);
        for (int s = 0; s < 8; s++)
        begin
            statusFive <= 8'(s << 4);
            repeat (3) @(posedge clk);
            check(32'(dummyClocks), (s < 5) ? 2 + 2 * s : 10);
        end
        xfer(1'b1, 32'h4, 32'hFFA5C3);
        cmd(32'h1DB);
        check(erases, 0);
        cmd(32'h006);
        check(32'(statusOne), 32'h2);
        cmd(32'h081);
        check(erases, 0);
        protect <= 1'b1;
        cmd(32'h1DB);
        check(erases, 0);
        protect <= 1'b0;
        for (int i = 0; i < 2; i++)
        begin
            eraseFail <= i[0];
            xfer(1'b1, 32'h4, i ? 32'h000100 : 32'hFFA5C3);
            cmd(32'h006);
            cmd(i ? 32'h1DB : 32'h181);
            check(erases, i + 1);
            check(32'(erasePage), i ? 32'h1 : 32'h1FA5);
            check(32'(statusOne), 32'h1);
            cmd(32'h205);
            check(rd, 32'h100);
            cmd(32'h325);
            check(32'(statusOne), 32'h0);
            check(32'(statusFour), i ? 32'h30 : 32'h0);
        end
        for (int q = 0; q < 3; q++)
        begin
            statusFive <= {7'h08, q == 0};
            xfer(1'b1, 32'hC, 32'h4);
            xfer(1'b1, 32'h4, 32'h123457);
            cmd(q == 2 ? 32'h4E7 : 32'h4EB);
            check(reads, q + 1);
            check(32'(readAddr), q == 1 ? 32'h123457 : 32'h123454);
            check(32'(contRead), 32'h0);
        end
        test_done();
    end
endmodule
`default_nettype wire

// *** tb/xip_erase_sva.sv ***
/*
 Link checker for the flash link.
 Assumes the link signals of spi_link_if and the host clock.
*/
`timescale 1ns/10ps
`default_nettype none
module xip_erase_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link
    input wire logic sck,
    input wire logic csN,
    input wire logic [3:0] hostIoOut,
    input wire logic [3:0] hostIoOe_n,
    input wire logic devSoOe_n
);
    //--------------------------------------------------------
    // Frame tracking
    //--------------------------------------------------------
    logic [6:0] bits;
    logic [7:0] opc;
    logic quad;
    wire logic frameIdle = !rst_n || csN;
    always_ff @(posedge clk)
    begin
        if (frameIdle)
            bits <= 7'h00;
        else if ($rose(sck) && bits != 7'h7F)
            bits <= bits + 7'h01;
    end
    always_ff @(posedge clk)
    begin
        if (frameIdle)
            opc <= 8'h00;
        else if ($rose(sck) && bits < 7'h08)
            opc <= {opc[6:0], hostIoOut[0]};
    end
    always_ff @(posedge clk)
    begin
        if (frameIdle)
            quad <= 1'b0;
        else if (!hostIoOe_n[3])
            quad <= 1'b1;
    end
    wire logic eraseOpc = (opc == 8'h81) || (opc == 8'hDB);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    //--------------------------------------------------------
    // Properties
    //--------------------------------------------------------
    property p_byteEnd;
        $rose(csN) && !quad |-> bits[2:0] == 3'h0;
    endproperty
    a_byteEnd: assert property (p_byteEnd)
        else $error("chip select rose off a byte boundary");
    property p_siStable;
        $rose(sck) && !csN |-> $stable(hostIoOut[0]);
    endproperty
    a_siStable: assert property (p_siStable)
        else $error("serial input changed at clock rise");
    property p_opcDriven;
        !csN && !$past(csN) && bits < 7'h08 |-> !hostIoOe_n[0];
    endproperty
    a_opcDriven: assert property (p_opcDriven)
        else $error("opcode line not driven");
    property p_single;
        !csN && eraseOpc && bits >= 7'h08 |-> hostIoOe_n[3:1] == 3'h7;
    endproperty
    a_single: assert property (p_single)
        else $error("erase frame used more than one line");
    property p_idleLow;
        csN |-> !sck;
    endproperty
    a_idleLow: assert property (p_idleLow)
        else $error("serial clock high outside a frame");
    property p_gap;
        $rose(csN) |-> csN [*7];
    endproperty
    a_gap: assert property (p_gap)
        else $error("chip select high time too short");
    property p_soQuiet;
        csN && $past(csN, 5) |-> devSoOe_n;
    endproperty
    a_soQuiet: assert property (p_soQuiet)
        else $error("flash drives output while deselected");
    property p_asiDrive;
        !csN && opc == 8'h25 && bits >= 7'h0A |-> !devSoOe_n;
    endproperty
    a_asiDrive: assert property (p_asiDrive)
        else $error("busy not driven during status wait");
    c_erase: cover property ($rose(csN) && eraseOpc && bits == 7'h20);
    c_asi: cover property ($rose(csN) && opc == 8'h25);
    c_quad: cover property ($rose(csN) && quad);
endmodule
`default_nettype wire
